// ==== verilog/cmr_pkg.sv ====
// Constants and types shared by the macrocell logic block
`default_nettype none
package cmr_pkg;
	// Clock and array sizes
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int N_CELLS = 16;
	localparam int N_ROW = 33;
	localparam int N_PT = 5;
	localparam int N_SIG = 114;
	localparam int N_BASE_SIG = 98;
	localparam int N_MASK = 6;
	localparam int MASK_WORDS = 4;
	localparam int MAX_BORROW = 3;
	// Expander terms may not see other expanders, which would form a loop
	localparam logic [N_SIG-1:0] EXP_TERM_MASK = {{(N_SIG-N_BASE_SIG){1'b0}}, {N_BASE_SIG{1'b1}}};
	// Register port address fields
	localparam int ADDR_W = 12;
	localparam logic [1:0] RGN_MASK = 2'h0;
	localparam logic [1:0] RGN_CELL = 2'h1;
	localparam logic [1:0] RGN_GLOB = 2'h2;
	localparam int MA_CELL_LSB = 6;
	localparam int MA_SPARE = 5;
	localparam int MA_TERM_LSB = 2;
	localparam logic [3:0] OFS_GCFG = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;
	localparam logic [3:0] OFS_TCTRL = 4'h2;
	localparam logic [3:0] OFS_TSTAT = 4'h3;
	localparam logic [3:0] OFS_TCK_DIV = 4'h4;
	// Per-cell configuration fields
	localparam int CF_TYPE_LSB = 0;
	localparam int CF_BYPASS = 2;
	localparam int CF_MODE_LSB = 3;
	localparam int CF_GCLK_SEL = 5;
	localparam int CF_PACK = 6;
	localparam int CF_GCLR_EN = 7;
	localparam int CF_CLR_PT = 8;
	localparam int CF_PRE_PT = 9;
	localparam int CF_XOR_INV = 10;
	localparam int CF_K_PT = 11;
	localparam int CF_LOCAL_REG = 12;
	localparam int CF_GLOBAL_REG = 13;
	localparam int CF_OR_LSB = 16;
	localparam int CF_LEND_LSB = 21;
	localparam int CF_BORROW_LSB = 26;
	localparam logic [31:0] CELL_CFG_RST = 32'h0000_0000;
	// Global configuration fields
	localparam int GCFG_W = 5;
	localparam int GC_CLK_LSB = 0;
	localparam int GC_CLR_POL = 4;
	localparam logic [GCFG_W-1:0] GCFG_RST = 5'h10;
	// Timer control and status bits
	localparam int TC_START_PROG = 0;
	localparam int TC_START_VER = 1;
	localparam int TC_CLR_DONE = 2;
	localparam logic [15:0] TCK_DIV_RST = 16'h0003;
	// Programming and verification times
	localparam int unsigned FIXED_PROGRAM_PULSE_TIME_MS = 12420;
	localparam int unsigned FIXED_VERIFY_PULSE_TIME_MS = 150;
	localparam int unsigned PROGRAM_TEST_CLOCK_CYCLES = 4_164_000;
	localparam int unsigned VERIFY_TEST_CLOCK_CYCLES = 2_658_000;
	localparam int unsigned PROG_PULSE_CLKS = FIXED_PROGRAM_PULSE_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned VERIFY_PULSE_CLKS = FIXED_VERIFY_PULSE_TIME_MS * (CLK_HZ / 1000);
	// Types
	typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} cmr_ff_t;
	typedef enum logic [1:0] {MODE_GLOBAL, MODE_GATED, MODE_ARRAY} cmr_mode_t;
	typedef enum logic [1:0] {T_IDLE, T_PULSE, T_TCK} cmr_tstate_t;
endpackage : cmr_pkg
`default_nettype wire

// ==== verilog/cmr_logic_block.sv ====
// Logic array block of sixteen programmable macrocells with timer
// Behaviour
// - Block sees 33 row inputs and 16 cell feedbacks, true and inverted.
// - Each product term selects from 114 candidate signals.
// - Two global clocks and one global clear reach all sixteen cells.
// - Every cell owns five product terms.
// - Terms route to OR/XOR gates or to clear, preset, clock, enable.
// - Each cell's flipflop works as D, T, JK or SR.
// - Bypass outputs the combinational result instead of the flipflop.
// - Mode one clocks directly from a selected global clock.
// - Mode two uses a global clock gated by active-high enable.
// - Mode three clocks from a product term.
// - Each global clock is true or inverted form of either pin.
// - Product-term preset and clear act immediately, active high.
// - Clear may also come from the global clear pin, per cell.
// - Global clear polarity is programmable.
// - Packing gives one term to D, others form a separate function.
// - Registered and combinational outputs drive local or global independently.
// - Up to fifteen terms borrowed from neighbours join a cell's OR.
// - Sixteen shared expander terms feed back inverted only.
// - Programming time is fixed pulse plus test clock cycles over rate.
// - Verification time is fixed pulse plus verify cycles over rate.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cmr_logic_block
	import cmr_pkg::*;
#(
	parameter int unsigned PROG_PULSE_CYCLES = PROG_PULSE_CLKS,
	parameter int unsigned VERIFY_PULSE_CYCLES = VERIFY_PULSE_CLKS,
	parameter int unsigned PROG_TCK_CYCLES = PROGRAM_TEST_CLOCK_CYCLES,
	parameter int unsigned VERIFY_TCK_CYCLES = VERIFY_TEST_CLOCK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Device pins
	input wire logic [N_ROW-1:0] row_in,
	input wire logic global_clock_pin_a,
	input wire logic global_clock_pin_b,
	input wire logic global_clear_pin,
	// Cell outputs
	output logic [N_CELLS-1:0] cell_reg_out,
	output logic [N_CELLS-1:0] cell_comb_out,
	output logic [N_CELLS-1:0] global_drive,
	// Programming timer
	output logic prog_busy,
	output logic prog_done
);
	// Counts of zero would wrap the timer
	if (PROG_PULSE_CYCLES < 1 || VERIFY_PULSE_CYCLES < 1 || PROG_TCK_CYCLES < 1
		|| VERIFY_TCK_CYCLES < 1) begin : g_bad_count
		$error("timer counts must be at least one");
	end

	// Product term: AND of selected signals, an empty term stays low
	function automatic logic pterm(input logic [N_SIG-1:0] m, input logic [N_SIG-1:0] s);
		return (|m) & (&(~m | s));
	endfunction : pterm
	// Address decode helpers shared by write and read paths; put_word serves writes only, get_word reads only
	function automatic logic [1:0] addr_region(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: 2];
	endfunction : addr_region
	function automatic logic mask_hit(input logic [ADDR_W-1:0] a);
		return addr_region(a) == RGN_MASK && !a[MA_SPARE] && a[MA_TERM_LSB +: 3] < 3'(N_MASK);
	endfunction : mask_hit
	function automatic logic cell_hit(input logic [ADDR_W-1:0] a);
		return addr_region(a) == RGN_CELL && a[ADDR_W-3:4] == '0;
	endfunction : cell_hit
	function automatic logic [N_SIG-1:0] put_word(input logic [N_SIG-1:0] old,
		input logic [1:0] w, input logic [31:0] v);
		logic [MASK_WORDS*32-1:0] wide;
		wide = {{(MASK_WORDS*32-N_SIG){1'b0}}, old};
		wide[w*32 +: 32] = v;
		return wide[N_SIG-1:0];
	endfunction : put_word
	function automatic logic [31:0] get_word(input logic [N_SIG-1:0] old, input logic [1:0] w);
		logic [MASK_WORDS*32-1:0] wide;
		wide = {{(MASK_WORDS*32-N_SIG){1'b0}}, old};
		return wide[w*32 +: 32];
	endfunction : get_word
	// Storage and state
	logic [N_SIG-1:0] mask_reg [N_CELLS][N_MASK];
	logic [31:0] cell_cfg_reg [N_CELLS];
	logic [GCFG_W-1:0] gcfg_reg;
	logic [N_ROW-1:0] row_meta_reg, row_sync_reg;
	logic [2:0] pin_meta_reg, pin_sync_reg;
	logic [1:0] gclk_prev_reg, gclk_lvl, gclk_tick;
	logic [N_CELLS-1:0] q_reg, comb_reg, drive_reg, pt3_prev_reg, gclr_en_v, bypass_v;
	logic [N_CELLS-1:0] q_next, comb_now, drive_now, pt3_now, fb, exp_pt, lend;
	logic [N_CELLS-1:0] clr_v, pre_v, ceoff_v, d_v, pack_v, pt0_v, dg_v, arr_idle_v;
	logic [N_BASE_SIG-1:0] base_sig;
	logic [N_SIG-1:0] sig;
	logic [N_CELLS+MAX_BORROW-1:0] lend_pad;
	logic [31:0] rd_mux, rdata_reg, cnt_reg;
	cmr_tstate_t tstate_reg;
	logic gclr_act, kind_reg, busy_reg, done_reg, finish, wr_glob, start_prog, start_ver;
	logic [15:0] tck_div_reg, div_cnt_reg;
	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (reset) begin
			row_meta_reg <= '0;
			row_sync_reg <= '0;
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			row_meta_reg <= row_in;
			row_sync_reg <= row_meta_reg;
			pin_meta_reg <= {global_clear_pin, global_clock_pin_b, global_clock_pin_a};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	// Global clock selection and edge detect; one enable pulse per rising edge
	for (genvar g = 0; g < 2; g++) begin : g_gclk
		assign gclk_lvl[g] = pin_sync_reg[gcfg_reg[GC_CLK_LSB+2*g]]
			^ gcfg_reg[GC_CLK_LSB+2*g+1];
	end
	assign gclk_tick = gclk_lvl & ~gclk_prev_reg;
	assign gclr_act = ~(pin_sync_reg[2] ^ gcfg_reg[GC_CLR_POL]);
	// Array inputs; expanders enter only in inverted form
	assign base_sig = {~fb, fb, ~row_sync_reg, row_sync_reg};
	assign sig = {~exp_pt, base_sig};
	assign lend_pad = {lend, {MAX_BORROW{1'b0}}};
	// Per-cell logic
	for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
		logic [31:0] cfg;
		logic [N_PT-1:0] pt, lendf, own;
		logic borrow, comb_or, xsum, d, clr, pre, k, tick, nxt, q, bp;
		cmr_mode_t mode;
		cmr_ff_t ftype;
		assign cfg = cell_cfg_reg[i];
		assign mode = cmr_mode_t'(cfg[CF_MODE_LSB +: 2]);
		assign ftype = cmr_ff_t'(cfg[CF_TYPE_LSB +: 2]);
		assign q = q_reg[i];
		assign bp = cfg[CF_BYPASS];
		for (genvar t = 0; t < N_PT; t++) begin : g_pt
			assign pt[t] = pterm(mask_reg[i][t], sig);
		end
		assign exp_pt[i] = pterm(mask_reg[i][N_PT] & EXP_TERM_MASK, sig);
		// Lent terms leave this cell's OR; packing removes term zero
		assign lendf = cfg[CF_LEND_LSB +: N_PT];
		assign own = cfg[CF_OR_LSB +: N_PT] & ~lendf & {{(N_PT-1){1'b1}}, ~cfg[CF_PACK]};
		assign lend[i] = |(pt & lendf);
		// Borrow from up to three lower neighbours, five terms each
		always_comb begin
			borrow = 1'b0;
			for (int n = 1; n <= MAX_BORROW; n++) begin
				if (n <= int'(cfg[CF_BORROW_LSB +: 2])) begin
					borrow = borrow | lend_pad[i+MAX_BORROW-n];
				end
			end
		end
		assign comb_or = |(pt & own) | borrow;
		assign xsum = comb_or ^ cfg[CF_XOR_INV];
		assign d = cfg[CF_PACK] ? pt[0] : xsum;
		// Control terms: one clear, two preset, three clock or enable, four K or R
		assign clr = (cfg[CF_CLR_PT] & pt[1]) | (cfg[CF_GCLR_EN] & gclr_act);
		assign pre = cfg[CF_PRE_PT] & pt[2];
		assign k = cfg[CF_K_PT] & pt[4];
		always_comb begin
			unique case (mode)
				MODE_GLOBAL: tick = gclk_tick[cfg[CF_GCLK_SEL]];
				MODE_GATED: tick = gclk_tick[cfg[CF_GCLK_SEL]] & pt[3];
				MODE_ARRAY: tick = pt[3] & ~pt3_prev_reg[i];
				default: tick = 1'b0;
			endcase
		end
		always_comb begin
			unique case (ftype)
				FF_D: nxt = d;
				FF_T: nxt = q ^ d;
				FF_JK: nxt = (d & ~q) | (~k & q);
				FF_SR: nxt = (d & k) ? q : (d | (q & ~k));
			endcase
		end
		assign q_next[i] = clr ? 1'b0 : (pre ? 1'b1 : (tick ? nxt : q));
		assign comb_now[i] = xsum;
		// Each output source picked on its own; bypass forces the combinational path
		assign drive_now[i] = (cfg[CF_GLOBAL_REG] & ~bp) ? q_next[i] : xsum;
		assign fb[i] = (cfg[CF_LOCAL_REG] & ~bp) ? q_reg[i] : comb_reg[i];
		assign pt3_now[i] = pt[3];
		// Views used by the checks below
		assign clr_v[i] = clr;
		assign pre_v[i] = pre;
		assign ceoff_v[i] = (mode == MODE_GATED) & ~pt[3];
		assign d_v[i] = d;
		assign pack_v[i] = cfg[CF_PACK];
		assign pt0_v[i] = pt[0];
		assign dg_v[i] = (mode == MODE_GLOBAL) & (ftype == FF_D) & tick;
		assign arr_idle_v[i] = (mode == MODE_ARRAY) & ~tick;
		assign gclr_en_v[i] = cfg[CF_GCLR_EN];
		assign bypass_v[i] = bp;
	end
	// Cell registers; outputs are taken from these flops
	always_ff @(posedge clk) begin
		if (reset) begin
			q_reg <= '0;
			comb_reg <= '0;
			drive_reg <= '0;
			pt3_prev_reg <= '0;
			gclk_prev_reg <= '0;
		end else begin
			q_reg <= q_next;
			comb_reg <= comb_now;
			drive_reg <= drive_now;
			pt3_prev_reg <= pt3_now;
			gclk_prev_reg <= gclk_lvl;
		end
	end
	// Configuration writes
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int c = 0; c < N_CELLS; c++) begin
				cell_cfg_reg[c] <= CELL_CFG_RST;
				for (int t = 0; t < N_MASK; t++) begin
					mask_reg[c][t] <= '0;
				end
			end
			gcfg_reg <= GCFG_RST;
		end else if (reg_wr) begin
			if (mask_hit(reg_addr)) begin
				mask_reg[reg_addr[MA_CELL_LSB +: 4]][reg_addr[MA_TERM_LSB +: 3]] <=
					put_word(mask_reg[reg_addr[MA_CELL_LSB +: 4]][reg_addr[MA_TERM_LSB +: 3]],
					reg_addr[1:0], reg_wdata);
			end else if (cell_hit(reg_addr)) begin
				cell_cfg_reg[reg_addr[3:0]] <= reg_wdata;
			end else if (wr_glob && reg_addr[3:0] == OFS_GCFG) begin
				gcfg_reg <= reg_wdata[GCFG_W-1:0];
			end
		end
	end
	// Timer commands; a start while busy is ignored
	assign wr_glob = addr_region(reg_addr) == RGN_GLOB && reg_addr[ADDR_W-3:4] == '0;
	assign start_prog = reg_wr && wr_glob && reg_addr[3:0] == OFS_TCTRL && reg_wdata[TC_START_PROG];
	assign start_ver = reg_wr && wr_glob && reg_addr[3:0] == OFS_TCTRL && reg_wdata[TC_START_VER]
		&& !reg_wdata[TC_START_PROG];
	assign finish = tstate_reg == T_TCK && div_cnt_reg == tck_div_reg && cnt_reg == '0;
	// Fixed pulse phase, then a count of test clock periods from the divider
	always_ff @(posedge clk) begin
		if (reset) begin
			tstate_reg <= T_IDLE;
			kind_reg <= 1'b0;
			busy_reg <= 1'b0;
			cnt_reg <= '0;
			div_cnt_reg <= '0;
			tck_div_reg <= TCK_DIV_RST;
		end else begin
			unique case (tstate_reg)
				T_IDLE: begin
					if (start_prog || start_ver) begin
						tstate_reg <= T_PULSE;
						kind_reg <= start_ver;
						busy_reg <= 1'b1;
						cnt_reg <= start_ver ? VERIFY_PULSE_CYCLES - 32'd1 : PROG_PULSE_CYCLES - 32'd1;
					end else if (reg_wr && wr_glob && reg_addr[3:0] == OFS_TCK_DIV) begin
						tck_div_reg <= reg_wdata[15:0];
					end
				end
				T_PULSE: begin
					if (cnt_reg == '0) begin
						tstate_reg <= T_TCK;
						div_cnt_reg <= '0;
						cnt_reg <= kind_reg ? VERIFY_TCK_CYCLES - 32'd1 : PROG_TCK_CYCLES - 32'd1;
					end else begin
						cnt_reg <= cnt_reg - 32'd1;
					end
				end
				T_TCK: begin
					if (div_cnt_reg == tck_div_reg) begin
						div_cnt_reg <= '0;
						if (cnt_reg == '0) begin
							tstate_reg <= T_IDLE;
							busy_reg <= 1'b0;
						end else begin
							cnt_reg <= cnt_reg - 32'd1;
						end
					end else begin
						div_cnt_reg <= div_cnt_reg + 16'h0001;
					end
				end
				default: tstate_reg <= T_IDLE;
			endcase
		end
	end
	// Done flag; completion wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			done_reg <= 1'b0;
		end else if (finish) begin
			done_reg <= 1'b1;
		end else if (reg_wr && wr_glob && reg_addr[3:0] == OFS_TCTRL && reg_wdata[TC_CLR_DONE]) begin
			done_reg <= 1'b0;
		end
	end
	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (mask_hit(reg_addr)) begin
			rd_mux = get_word(mask_reg[reg_addr[MA_CELL_LSB +: 4]][reg_addr[MA_TERM_LSB +: 3]],
				reg_addr[1:0]);
		end else if (cell_hit(reg_addr)) begin
			rd_mux = cell_cfg_reg[reg_addr[3:0]];
		end else if (wr_glob) begin
			unique case (reg_addr[3:0])
				OFS_GCFG: rd_mux = {{(32-GCFG_W){1'b0}}, gcfg_reg};
				OFS_STATUS: rd_mux = {comb_reg, q_reg};
				OFS_TSTAT: rd_mux = {28'h0000000, tstate_reg == T_TCK, kind_reg, done_reg, busy_reg};
				OFS_TCK_DIV: rd_mux = {16'h0000, tck_div_reg};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end
	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_reg;
	assign cell_reg_out = q_reg;
	assign cell_comb_out = comb_reg;
	assign global_drive = drive_reg;
	assign prog_busy = busy_reg;
	assign prog_done = done_reg;
	// Busy length tracker for the timer checks
	logic [63:0] busy_len_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_len_reg <= '0;
		end else begin
			busy_len_reg <= busy_reg ? busy_len_reg + 64'h1 : 64'h0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_clear_wins;
		(|clr_v) |=> ((q_reg & $past(clr_v)) == '0);
	endproperty
	a_clear_wins: assert property (p_clear_wins) else $error("cleared cell not low");
	property p_preset;
		(|(pre_v & ~clr_v)) |=> ((q_reg & $past(pre_v & ~clr_v)) == $past(pre_v & ~clr_v));
	endproperty
	a_preset: assert property (p_preset) else $error("preset cell not high");
	property p_ce_hold;
		(|(ceoff_v & ~clr_v & ~pre_v)) |=>
			(((q_reg ^ $past(q_reg)) & $past(ceoff_v & ~clr_v & ~pre_v)) == '0);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("disabled cell changed");
	property p_gclr;
		(gclr_act && (|gclr_en_v)) |=> ((q_reg & $past(gclr_en_v)) == '0);
	endproperty
	a_gclr: assert property (p_gclr) else $error("global clear missed");
	property p_global_d;
		(|(dg_v & ~clr_v & ~pre_v)) |=>
			((q_reg & $past(dg_v & ~clr_v & ~pre_v)) == ($past(d_v) & $past(dg_v & ~clr_v & ~pre_v)));
	endproperty
	a_global_d: assert property (p_global_d) else $error("global clock did not load");
	property p_array_idle;
		(|(arr_idle_v & ~clr_v & ~pre_v)) |=>
			(((q_reg ^ $past(q_reg)) & $past(arr_idle_v & ~clr_v & ~pre_v)) == '0);
	endproperty
	a_array_idle: assert property (p_array_idle) else $error("array clock cell moved");
	property p_pack;
		(|(pack_v & dg_v & ~clr_v & ~pre_v)) |=>
			(((q_reg ^ $past(pt0_v)) & $past(pack_v & dg_v & ~clr_v & ~pre_v)) == '0);
	endproperty
	a_pack: assert property (p_pack) else $error("packed input not term zero");
	property p_bypass;
		1'b1 |=> (((drive_reg ^ comb_reg) & $past(bypass_v)) == '0);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass output not combinational");
	property p_prog_len;
		($fell(busy_reg) && !kind_reg) |-> (busy_len_reg == 64'(PROG_PULSE_CYCLES)
			+ 64'(PROG_TCK_CYCLES) * (64'(tck_div_reg) + 64'h1));
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program time wrong");
	property p_ver_len;
		($fell(busy_reg) && kind_reg) |-> (busy_len_reg == 64'(VERIFY_PULSE_CYCLES)
			+ 64'(VERIFY_TCK_CYCLES) * (64'(tck_div_reg) + 64'h1));
	endproperty
	a_ver_len: assert property (p_ver_len) else $error("verify time wrong");
endmodule : cmr_logic_block
`default_nettype wire

// ==== test/cmr_logic_block_tb_top.sv ====
// Self-checking testbench for the macrocell logic block
`timescale 1ns/1ps
`default_nettype none
module cmr_logic_block_tb_top;
	import cmr_pkg::*;
	// Shortened timer counts, pin indices for put
	localparam int unsigned PP = 5;
	localparam int unsigned VP = 3;
	localparam int unsigned PN = 4;
	localparam int unsigned VN = 2;
	localparam int PA = 33;
	localparam int PB = 34;
	localparam int GC = 35;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [N_ROW-1:0] row_in = '0;
	logic pin_a = 1'b0;
	logic pin_b = 1'b0;
	logic clr_pin = 1'b0;
	logic [N_CELLS-1:0] q_out;
	logic [N_CELLS-1:0] comb_out;
	logic [N_CELLS-1:0] gdrv;
	logic prog_busy;
	logic prog_done;
	int err_total = 0;
	int num_checks = 0;
	int n;
	// Device under test with short timer counts
	cmr_logic_block #(.PROG_PULSE_CYCLES(PP), .VERIFY_PULSE_CYCLES(VP),
		.PROG_TCK_CYCLES(PN), .VERIFY_TCK_CYCLES(VN)) dut_u (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .row_in(row_in),
		.global_clock_pin_a(pin_a), .global_clock_pin_b(pin_b),
		.global_clear_pin(clr_pin), .cell_reg_out(q_out), .cell_comb_out(comb_out),
		.global_drive(gdrv), .prog_busy(prog_busy), .prog_done(prog_done));
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk32
	task automatic chk1(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// Register port cycles, strobes one cycle long
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk32(nm, e, reg_rdata);
	endtask : rd_chk
	// Let edges pass, then look where outputs are settled
	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
	endtask : settle
	// Drive a row input or one of the dedicated pins
	task automatic put(input int i, input logic v);
		@(posedge clk);
		if (i == PA) pin_a <= v;
		else if (i == PB) pin_b <= v;
		else if (i == GC) clr_pin <= v;
		else row_in[i] <= v;
	endtask : put
	task automatic tick(input logic b);
		put(PA + b, 1'b1);
		settle(4);
		put(PA + b, 1'b0);
		settle(4);
	endtask : tick
	// One flipflop step: set J/S and K/R rows, clock, compare
	task automatic step(input logic [31:0] cfg, input logic [1:0] r, input logic e);
		wr(12'h400, cfg);
		put(0, r[0]);
		put(1, r[1]);
		settle(3);
		tick(1'b0);
		chk1("q0", e, q_out[0]);
	endtask : step
	task automatic busy_len(output int c);
		c = 0;
		@(negedge clk);
		while (prog_busy === 1'b1 && c < 1000) begin
			c++;
			@(negedge clk);
		end
	endtask : busy_len
	task automatic t_reset;
		chk32("outs", 32'h0000_0000, {q_out, comb_out});
		rd_chk(12'h800, 32'h0000_0010, "gcfg");
		rd_chk(12'h804, 32'h0000_0003, "tck_div");
		rd_chk(12'h400, 32'h0000_0000, "cell_cfg");
		rd_chk(12'hC00, 32'h0000_0000, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_dff;
		// Term0 row0, term1 row2, term2 row3, term3 row4, term4 row1
		wr(12'h000, 32'h0000_0001);
		wr(12'h004, 32'h0000_0004);
		wr(12'h008, 32'h0000_0008);
		wr(12'h00C, 32'h0000_0010);
		wr(12'h010, 32'h0000_0002);
		// Inverted expanders of empty terms are ones, so term3 is unchanged
		wr(12'h00F, 32'hFFFF_FFFF);
		rd_chk(12'h00F, 32'h0003_FFFF, "mask word3");
		wr(12'h400, 32'h0001_0000);
		put(0, 1'b1);
		settle(3);
		tick(1'b0);
		chk1("q0", 1'b1, q_out[0]);
		chk1("comb0", 1'b1, comb_out[0]);
		put(0, 1'b0);
		tick(1'b0);
		chk1("q0", 1'b0, q_out[0]);
		wr(12'h800, 32'h0000_0012);
		put(0, 1'b1);
		settle(3);
		put(PA, 1'b1);
		settle(4);
		chk1("q0 inv rise", 1'b0, q_out[0]);
		put(PA, 1'b0);
		settle(4);
		chk1("q0 inv fall", 1'b1, q_out[0]);
		wr(12'h800, 32'h0000_0011);
		put(0, 1'b0);
		settle(3);
		tick(1'b0);
		chk1("q0 pin a", 1'b1, q_out[0]);
		tick(1'b1);
		chk1("q0 pin b", 1'b0, q_out[0]);
		wr(12'h400, 32'h0001_0020);
		wr(12'h800, 32'h0000_0014);
		put(0, 1'b1);
		settle(3);
		tick(1'b0);
		chk1("q0 clk1 a", 1'b0, q_out[0]);
		tick(1'b1);
		chk1("q0 clk1 b", 1'b1, q_out[0]);
		wr(12'h800, 32'h0000_0010);
		$display("test dff done");
	endtask : t_dff
	task automatic t_types;
		step(32'h0001_0001, 2'b01, 1'b0);
		step(32'h0001_0001, 2'b01, 1'b1);
		step(32'h0001_0802, 2'b10, 1'b0);
		step(32'h0001_0802, 2'b01, 1'b1);
		step(32'h0001_0802, 2'b11, 1'b0);
		step(32'h0001_0803, 2'b01, 1'b1);
		step(32'h0001_0803, 2'b10, 1'b0);
		step(32'h0001_0803, 2'b01, 1'b1);
		step(32'h0001_0803, 2'b11, 1'b1);
		$display("test types done");
	endtask : t_types
	task automatic t_modes;
		wr(12'h400, 32'h0001_0008);
		put(0, 1'b0);
		put(4, 1'b0);
		settle(3);
		tick(1'b0);
		chk1("q0 gated off", 1'b1, q_out[0]);
		put(4, 1'b1);
		settle(3);
		tick(1'b0);
		chk1("q0 gated on", 1'b0, q_out[0]);
		wr(12'h400, 32'h0001_0010);
		put(4, 1'b0);
		put(0, 1'b1);
		settle(3);
		tick(1'b0);
		chk1("q0 array idle", 1'b0, q_out[0]);
		put(4, 1'b1);
		settle(6);
		chk1("q0 array clk", 1'b1, q_out[0]);
		step(32'h0001_0018, 2'b00, 1'b1);
		$display("test modes done");
	endtask : t_modes
	task automatic t_clear;
		wr(12'h400, 32'h0001_0380);
		put(2, 1'b1);
		settle(5);
		chk1("q0 clear", 1'b0, q_out[0]);
		put(2, 1'b0);
		put(3, 1'b1);
		settle(5);
		chk1("q0 preset", 1'b1, q_out[0]);
		put(2, 1'b1);
		settle(5);
		chk1("q0 both", 1'b0, q_out[0]);
		put(2, 1'b0);
		settle(2);
		put(3, 1'b0);
		settle(5);
		chk1("q0 after preset", 1'b1, q_out[0]);
		put(GC, 1'b1);
		settle(5);
		chk1("q0 gclr high", 1'b0, q_out[0]);
		put(GC, 1'b0);
		put(3, 1'b1);
		settle(2);
		put(3, 1'b0);
		wr(12'h800, 32'h0000_0000);
		settle(5);
		chk1("q0 gclr low", 1'b0, q_out[0]);
		put(GC, 1'b1);
		put(3, 1'b1);
		settle(2);
		put(3, 1'b0);
		settle(5);
		chk1("q0 gclr idle", 1'b1, q_out[0]);
		wr(12'h800, 32'h0000_0010);
		put(GC, 1'b0);
		settle(5);
		$display("test clear done");
	endtask : t_clear
	task automatic t_outputs;
		wr(12'h400, 32'h0001_2004);
		put(0, 1'b1);
		settle(5);
		chk1("comb0 bypass", 1'b1, comb_out[0]);
		chk1("gdrv0 bypass", 1'b1, gdrv[0]);
		rd_chk(12'h801, 32'h0001_0000, "status");
		wr(12'h400, 32'h0001_2000);
		settle(3);
		chk1("gdrv0 reg", 1'b0, gdrv[0]);
		wr(12'h400, 32'h0011_2040);
		put(1, 1'b0);
		settle(5);
		chk1("comb0 packed", 1'b0, comb_out[0]);
		tick(1'b0);
		chk1("q0 packed", 1'b1, q_out[0]);
		put(1, 1'b1);
		settle(5);
		chk1("comb0 term4", 1'b1, comb_out[0]);
		$display("test outputs done");
	endtask : t_outputs
	task automatic t_timer;
		wr(12'h802, 32'h0000_0001);
		// Start of verify and divider change while busy must be ignored
		fork
			begin
				wr(12'h802, 32'h0000_0002);
				wr(12'h804, 32'h0000_0000);
			end
			busy_len(n);
		join
		chk32("prog len", 32'(PP + PN * 4), 32'(n));
		chk1("done", 1'b1, prog_done);
		rd_chk(12'h803, 32'h0000_0002, "tstat prog");
		rd_chk(12'h804, 32'h0000_0003, "tck_div kept");
		wr(12'h802, 32'h0000_0004);
		settle(1);
		chk1("done cleared", 1'b0, prog_done);
		wr(12'h804, 32'h0000_0001);
		wr(12'h802, 32'h0000_0002);
		busy_len(n);
		chk32("verify len", 32'(VP + VN * 2), 32'(n));
		rd_chk(12'h803, 32'h0000_0006, "tstat verify");
		$display("test timer done");
	endtask : t_timer
	// Borrowed terms, shared expander and local feedback between two cells
	task automatic t_array;
		// Cell 0: term0 row0 in OR, term4 row1 lent out, term5 row0 as expander
		wr(12'h014, 32'h0000_0001);
		wr(12'h400, 32'h0211_0000);
		// Cell 1: term0 inverted expander, term1 cell 0 feedback and row3, inverted OR
		wr(12'h043, 32'h0000_0004);
		wr(12'h044, 32'h0000_0008);
		wr(12'h046, 32'h0000_0004);
		wr(12'h401, 32'h0403_0400);
		put(1, 1'b0);
		settle(5);
		chk1("comb1 idle", 1'b1, comb_out[1]);
		put(1, 1'b1);
		settle(5);
		chk1("comb1 borrow", 1'b0, comb_out[1]);
		put(0, 1'b0);
		settle(5);
		chk1("comb0 lent", 1'b0, comb_out[0]);
		put(1, 1'b0);
		settle(5);
		chk1("comb1 expander", 1'b0, comb_out[1]);
		put(0, 1'b1);
		put(3, 1'b1);
		settle(5);
		chk1("comb1 feedback", 1'b0, comb_out[1]);
		$display("test array done");
	endtask : t_array
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		settle(1);
		t_reset;
		t_dff;
		t_types;
		t_modes;
		t_clear;
		t_outputs;
		t_array;
		t_timer;
		test_done;
	end
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		$display("watchdog expired");
		test_done;
	end
endmodule : cmr_logic_block_tb_top
`default_nettype wire
